// ---- verilog/prc_regs.vh ----
`ifndef PRC_REGS_VH
`define PRC_REGS_VH

// Summary of operation
// [RULE1] Bits 0 and 1 hold serial ports 0 and 1 in reset at 0, release them at 1, reset to 1.
// [RULE2] Bit 2 holds the shared baud fractional generator in reset at 0 and runs it at 1.
// [RULE3] Bits 3, 4 and 5 hold USARTs A, B and C in reset at 0 and release them at 1.
// [RULE4] Bit 6 resets the I2C controller and bit 7 the multi-rate timer while 0.
// [RULE5] Bit 8 resets the state timer and bit 9 the wake-up timer while 0.
// [RULE6] Bit 10 at 0 holds GPIO and its pin-interrupt logic in reset, and 1 frees both.
// [RULE7] Bit 11 resets the flash controller and bit 12 the comparator logic while 0.
// [RULE8] PLL control bits 4:0 give a feedback ratio M of field plus one, 1 to 32.
// [RULE9] PLL control bits 6:5 give P of 1, 2, 4 or 8 and an applied post ratio of 2P.
// [RULE10] Software never writes ones into PLL control bits 31:7.
// [RULE11] Software keeps the resulting PLL output frequency below 100 MHz.
// [RULE12] The PLL status word is read-only, bit 0 shows lock, and it resets to 0.
// [RULE13] Every assigned peripheral reset bit is active low: 0 resets, 1 runs.
// [RULE14] The raw lock level passes a two-stage synchroniser before the status bit.
// [RULE15] Reserved bits ignore writes and read as zero.

// Register byte addresses
`define PRC_ADDR_PRESET 32'h40048004
`define PRC_ADDR_PLLCTRL 32'h40048008
`define PRC_ADDR_PLLSTAT 32'h4004800c

// Peripheral reset word
`define PRC_PRESET_W 13
`define PRC_PRESET_RST 13'h1fff
`define PRC_SPI0_BIT 0
`define PRC_SPI1_BIT 1
`define PRC_FRG_BIT 2
`define PRC_USARTA_BIT 3
`define PRC_USARTB_BIT 4
`define PRC_USARTC_BIT 5
`define PRC_I2C_BIT 6
`define PRC_MTMR_BIT 7
`define PRC_STMR_BIT 8
`define PRC_WAKE_BIT 9
`define PRC_GPIO_BIT 10
`define PRC_FLASH_BIT 11
`define PRC_ACMP_BIT 12

// PLL control word
`define PRC_FBDIV_MSB 4
`define PRC_FBDIV_LSB 0
`define PRC_FBDIV_RST 5'h00
`define PRC_PSEL_MSB 6
`define PRC_PSEL_LSB 5
`define PRC_PSEL_RST 2'h0

// PLL status word
`define PRC_LOCK_BIT 0
`define PRC_LOCK_RST 1'h0

`endif

// ---- verilog/prc_sync2.v ----
`timescale 1ns/100ps
`default_nettype none

module prc_sync2 (
    input wire sys_clk,
    input wire srst,
    input wire asyncIn,
    output reg syncOut
);

    reg stage1;

    // Stage one feeds stage two only, to keep metastability contained
    always @(posedge sys_clk) begin
        if (srst) begin
            stage1 <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule

`default_nettype wire

// ---- verilog/prc_pll_decode.v ----
`timescale 1ns/100ps
`default_nettype none

module prc_pll_decode (
    input wire [4:0] feedbackDivSel,
    input wire [1:0] postDivSel,
    output wire [5:0] feedbackRatio,
    output wire [4:0] postDivRatio
);

    // Applied post ratio is 2P with P = 1, 2, 4, 8
    function [4:0] postRatio;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: postRatio = 5'h02;
                2'h1: postRatio = 5'h04;
                2'h2: postRatio = 5'h08;
                default: postRatio = 5'h10;
            endcase
        end
    endfunction

    assign feedbackRatio = {1'b0, feedbackDivSel} + 6'h01; // [RULE8]
    assign postDivRatio = postRatio(postDivSel); // [RULE9]

endmodule

`default_nettype wire

// ---- verilog/prc_top.v ----
`timescale 1ns/100ps
`default_nettype none
`include "prc_regs.vh"

module prc_top (
    input wire sys_clk,
    input wire srst,

    input wire [31:0] busAddr,
    input wire [31:0] busWrData,
    input wire busWr,
    input wire busRd,
    output reg [31:0] busRdData,

    input wire pllLockRaw,

    output reg serialPort0ResetN,
    output reg serialPort1ResetN,
    output reg baudFracGenResetN,
    output reg usartAResetN,
    output reg usartBResetN,
    output reg usartCResetN,
    output reg i2cResetN,
    output reg multirateTimerResetN,
    output reg stateTimerResetN,
    output reg wakeTimerResetN,
    output reg gpioResetN,
    output reg pinIntResetN,
    output reg flashCtrlResetN,
    output reg comparatorResetN,

    output reg [4:0] feedbackDivSel,
    output reg [1:0] postDivSel,
    output reg [5:0] feedbackRatio,
    output reg [4:0] postDivRatio,
    output reg pllConfigUpdate,
    output reg pllLockChange
);

    ////////////////////////////////////////////////////////////////////////

    wire wrPreset;
    wire wrPllCtrl;
    wire lockSync;
    wire [5:0] next_feedbackRatio;
    wire [4:0] next_postDivRatio;
    reg pllLocked;
    reg wrPllCtrlDly;
    reg [31:0] next_busRdData;

    // Address match on the full byte address
    function hit;
        input [31:0] addr;
        input [31:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    assign wrPreset = busWr & hit(busAddr, `PRC_ADDR_PRESET);
    assign wrPllCtrl = busWr & hit(busAddr, `PRC_ADDR_PLLCTRL);

    ////////////////////////////////////////////////////////////////////////
    // Peripheral reset word

    // Each output is its own storage bit, so a write reaches the
    // peripheral on the next edge with no extra pipeline stage.
    always @(posedge sys_clk) begin
        if (srst) begin
            serialPort0ResetN <= 1'b1; // [RULE1]
            serialPort1ResetN <= 1'b1; // [RULE1]
            baudFracGenResetN <= 1'b1;
            usartAResetN <= 1'b1;
            usartBResetN <= 1'b1;
            usartCResetN <= 1'b1;
            i2cResetN <= 1'b1;
            multirateTimerResetN <= 1'b1;
            stateTimerResetN <= 1'b1;
            wakeTimerResetN <= 1'b1;
            gpioResetN <= 1'b1;
            pinIntResetN <= 1'b1;
            flashCtrlResetN <= 1'b1;
            comparatorResetN <= 1'b1;
        end else if (wrPreset) begin
            // A 0 asserts the peripheral reset, a 1 clears it
            serialPort0ResetN <= busWrData[`PRC_SPI0_BIT]; // [RULE1] [RULE13]
            serialPort1ResetN <= busWrData[`PRC_SPI1_BIT]; // [RULE1] [RULE13]

            baudFracGenResetN <= busWrData[`PRC_FRG_BIT]; // [RULE2] [RULE13]

            usartAResetN <= busWrData[`PRC_USARTA_BIT]; // [RULE3]
            usartBResetN <= busWrData[`PRC_USARTB_BIT]; // [RULE3]
            usartCResetN <= busWrData[`PRC_USARTC_BIT]; // [RULE3]

            i2cResetN <= busWrData[`PRC_I2C_BIT]; // [RULE4]
            multirateTimerResetN <= busWrData[`PRC_MTMR_BIT]; // [RULE4]

            stateTimerResetN <= busWrData[`PRC_STMR_BIT]; // [RULE5]
            wakeTimerResetN <= busWrData[`PRC_WAKE_BIT]; // [RULE5]

            // One bit drives both GPIO and pin-interrupt resets
            gpioResetN <= busWrData[`PRC_GPIO_BIT]; // [RULE6]
            pinIntResetN <= busWrData[`PRC_GPIO_BIT]; // [RULE6]

            flashCtrlResetN <= busWrData[`PRC_FLASH_BIT]; // [RULE7]
            comparatorResetN <= busWrData[`PRC_ACMP_BIT]; // [RULE7]
            // Bits 31:13 are not stored // [RULE15]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PLL control word

    // Only bits 6:0 are stored; ones in 31:7 from software are dropped
    // rather than trusted, since the PLL has no use for them.
    always @(posedge sys_clk) begin
        if (srst) begin
            feedbackDivSel <= `PRC_FBDIV_RST;
            postDivSel <= `PRC_PSEL_RST;
        end else if (wrPllCtrl) begin
            feedbackDivSel <= busWrData[`PRC_FBDIV_MSB:`PRC_FBDIV_LSB]; // [RULE8] [RULE10]
            postDivSel <= busWrData[`PRC_PSEL_MSB:`PRC_PSEL_LSB]; // [RULE9] [RULE10]
        end
    end

    prc_pll_decode u_decode (
        .feedbackDivSel(feedbackDivSel),
        .postDivSel(postDivSel),
        .feedbackRatio(next_feedbackRatio),
        .postDivRatio(next_postDivRatio)
    );

    // Ratios are registered so the PLL sees glitch-free divider values;
    // they trail the select fields by one cycle.
    always @(posedge sys_clk) begin
        if (srst) begin
            feedbackRatio <= 6'h01;
            postDivRatio <= 5'h02;
        end else begin
            feedbackRatio <= next_feedbackRatio; // [RULE8]
            postDivRatio <= next_postDivRatio; // [RULE9]
        end
    end

    // Tells the PLL that new ratios stand, in the cycle they first appear
    always @(posedge sys_clk) begin
        if (srst) begin
            pllConfigUpdate <= 1'b0;
        end else begin
            pllConfigUpdate <= wrPllCtrlDly;
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            wrPllCtrlDly <= 1'b0;
        end else begin
            wrPllCtrlDly <= wrPllCtrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PLL lock status

    // The lock level comes from the analog PLL with no relation to
    // sys_clk, so it is synchronised before anything looks at it.
    prc_sync2 u_lockSync (
        .sys_clk(sys_clk),
        .srst(srst),
        .asyncIn(pllLockRaw),
        .syncOut(lockSync)
    ); // [RULE14]

    always @(posedge sys_clk) begin
        if (srst) begin
            pllLocked <= `PRC_LOCK_RST; // [RULE12]
            pllLockChange <= 1'b0;
        end else begin
            pllLocked <= lockSync; // [RULE14]
            pllLockChange <= pllLocked ^ lockSync;
        end
    end

    // No write path exists for the status word // [RULE12]

    ////////////////////////////////////////////////////////////////////////
    // Read path

    always @* begin
        next_busRdData = 32'h00000000;
        case (busAddr)
            `PRC_ADDR_PRESET: begin
                next_busRdData[`PRC_SPI0_BIT] = serialPort0ResetN;
                next_busRdData[`PRC_SPI1_BIT] = serialPort1ResetN;
                next_busRdData[`PRC_FRG_BIT] = baudFracGenResetN;
                next_busRdData[`PRC_USARTA_BIT] = usartAResetN;
                next_busRdData[`PRC_USARTB_BIT] = usartBResetN;
                next_busRdData[`PRC_USARTC_BIT] = usartCResetN;
                next_busRdData[`PRC_I2C_BIT] = i2cResetN;
                next_busRdData[`PRC_MTMR_BIT] = multirateTimerResetN;
                next_busRdData[`PRC_STMR_BIT] = stateTimerResetN;
                next_busRdData[`PRC_WAKE_BIT] = wakeTimerResetN;
                next_busRdData[`PRC_GPIO_BIT] = gpioResetN;
                next_busRdData[`PRC_FLASH_BIT] = flashCtrlResetN;
                next_busRdData[`PRC_ACMP_BIT] = comparatorResetN;
            end
            `PRC_ADDR_PLLCTRL: begin
                next_busRdData[`PRC_FBDIV_MSB:`PRC_FBDIV_LSB] = feedbackDivSel;
                next_busRdData[`PRC_PSEL_MSB:`PRC_PSEL_LSB] = postDivSel;
            end
            `PRC_ADDR_PLLSTAT: begin
                next_busRdData[`PRC_LOCK_BIT] = pllLocked; // [RULE12]
            end
            default: begin
                next_busRdData = 32'h00000000;
            end
        endcase
    end

    // Data stand for one cycle after the strobe, zero otherwise, so
    // unmapped addresses and reserved bits all read as zero.
    always @(posedge sys_clk) begin
        if (srst) begin
            busRdData <= 32'h00000000;
        end else if (busRd) begin
            busRdData <= next_busRdData; // [RULE15]
        end else begin
            busRdData <= 32'h00000000;
        end
    end

endmodule

`default_nettype wire

// ---- sim/prc_top_props.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "prc_regs.vh"

module prc_top_props (
    input wire sys_clk,
    input wire srst,
    input wire [31:0] busAddr,
    input wire [31:0] busWrData,
    input wire busWr,
    input wire busRd,
    input wire [31:0] busRdData,
    input wire pllLockRaw,
    input wire serialPort0ResetN,
    input wire serialPort1ResetN,
    input wire baudFracGenResetN,
    input wire usartAResetN,
    input wire usartBResetN,
    input wire usartCResetN,
    input wire i2cResetN,
    input wire multirateTimerResetN,
    input wire stateTimerResetN,
    input wire wakeTimerResetN,
    input wire gpioResetN,
    input wire pinIntResetN,
    input wire flashCtrlResetN,
    input wire comparatorResetN,
    input wire [4:0] feedbackDivSel,
    input wire [1:0] postDivSel,
    input wire [5:0] feedbackRatio,
    input wire [4:0] postDivRatio,
    input wire pllConfigUpdate,
    input wire pllLockChange
);
    wire [12:0] rstVec = {comparatorResetN, flashCtrlResetN, gpioResetN, wakeTimerResetN,
        stateTimerResetN, multirateTimerResetN, i2cResetN, usartCResetN, usartBResetN,
        usartAResetN, baudFracGenResetN, serialPort1ResetN, serialPort0ResetN};
    wire hitPre = busAddr == `PRC_ADDR_PRESET;
    wire hitPll = busAddr == `PRC_ADDR_PLLCTRL;
    wire hitMap = hitPre || hitPll || busAddr == `PRC_ADDR_PLLSTAT;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    sequence pllWrite;
        busWr && hitPll;
    endsequence
    // Lock must be held long enough to clear both synchroniser stages
    sequence rawHeld;
        $rose(pllLockRaw) ##1 pllLockRaw [*2];
    endsequence

    ////////////////////////////////////////////////////////////////
    idle_rd_zero_a: assert property (!busRd |=> busRdData == 32'h0)
        else $error("read data not idle");
    preset_rd_a: assert property (busRd && hitPre |=>
        busRdData == {19'h0, $past(rstVec)})
        else $error("reset word read");
    preset_wr_a: assert property (busWr && hitPre |=>
        rstVec == $past(busWrData[12:0]))
        else $error("reset word write");
    gpio_pair_a: assert property (gpioResetN == pinIntResetN)
        else $error("gpio pair split");
    pll_wr_a: assert property (pllWrite |=> feedbackDivSel == $past(busWrData[4:0])
        && postDivSel == $past(busWrData[6:5]) ##1 pllConfigUpdate)
        else $error("pll write");
    fb_ratio_a: assert property (1 |=> feedbackRatio ==
        {1'b0, $past(feedbackDivSel)} + 6'h1)
        else $error("feedback ratio");
    post_ratio_a: assert property (1 |=> postDivRatio == (5'h2 << $past(postDivSel)))
        else $error("post ratio");
    lock_sync_a: assert property (rawHeld |=> pllLockChange)
        else $error("lock change late");
    stray_wr_a: assert property (busWr && !hitMap |=> $stable(rstVec)
        && $stable({feedbackDivSel, postDivSel}))
        else $error("stray write");
endmodule

bind prc_top prc_top_props i_prc_top_props (.*);

`default_nettype wire

// ---- sim/prc_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "prc_regs.vh"

module prc_top_tb;
    logic sys_clk = 0, srst = 1, busWr = 0, busRd = 0, pllLockRaw = 0;
    logic [31:0] busAddr = 0, busWrData = 0, d;
    wire [31:0] busRdData;
    wire serialPort0ResetN, serialPort1ResetN, baudFracGenResetN, usartAResetN, usartBResetN;
    wire usartCResetN, i2cResetN, multirateTimerResetN, stateTimerResetN, wakeTimerResetN;
    wire gpioResetN, pinIntResetN, flashCtrlResetN, comparatorResetN;
    wire [4:0] feedbackDivSel, postDivRatio;
    wire [1:0] postDivSel;
    wire [5:0] feedbackRatio;
    wire pllConfigUpdate, pllLockChange;
    wire [12:0] rstVec = {comparatorResetN, flashCtrlResetN, gpioResetN, wakeTimerResetN,
        stateTimerResetN, multirateTimerResetN, i2cResetN, usartCResetN, usartBResetN,
        usartAResetN, baudFracGenResetN, serialPort1ResetN, serialPort0ResetN};
    int errCount = 0, compares = 0, cycles = 0;

    prc_top i_prc_top (.*);

    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [31:0] a, dat);
        @(posedge sys_clk);
        busWr <= 1'b1;
        busAddr <= a;
        busWrData <= dat;
        @(posedge sys_clk);
        busWr <= 1'b0;
    endtask

    // Read data stands for one cycle only, so it is captured just after the edge
    task automatic rd(input logic [31:0] a);
        @(posedge sys_clk);
        busRd <= 1'b1;
        busAddr <= a;
        @(posedge sys_clk);
        busRd <= 1'b0;
        #1 d = busRdData;
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic checkReset;
        check("resets", rstVec, 32'h1fff);
        check("ratios", {feedbackRatio, postDivRatio, feedbackDivSel, postDivSel},
            18'h01100);
        rd(`PRC_ADDR_PRESET);
        check("preset", d, 32'h1fff);
        rd(`PRC_ADDR_PLLCTRL);
        check("pll", d, 32'h0);
        rd(`PRC_ADDR_PLLSTAT);
        check("lock", d, 32'h0);
    endtask

    task automatic testPreset;
        for (int i = 0; i < 13; i++) begin
            wr(`PRC_ADDR_PRESET, ~(32'h1 << i));
            #1 check("reset bit", rstVec, 32'h1fff ^ (32'h1 << i));
            check("pin int", pinIntResetN, i != 10);
            rd(`PRC_ADDR_PRESET);
            check("preset", d, 32'h1fff ^ (32'h1 << i));
        end
        wr(`PRC_ADDR_PRESET, 32'h1fff);
    endtask

    task automatic testPll;
        for (int p = 0; p < 4; p++) begin
            for (int m = 0; m < 32; m += 31) begin
                wr(`PRC_ADDR_PLLCTRL, (p << 5) | m);
                @(posedge sys_clk);
                #1 check("update", pllConfigUpdate, 32'h1);
                check("fb ratio", feedbackRatio, m + 1);
                check("post ratio", postDivRatio, 2 << p);
                rd(`PRC_ADDR_PLLCTRL);
                check("pll", d, (p << 5) | m);
            end
        end
    endtask

    task automatic testStray;
        wr(`PRC_ADDR_PRESET, 32'h1555);
        wr(32'h40048000, 32'h0);
        wr(`PRC_ADDR_PLLSTAT, 32'h1);
        #1 check("stray", rstVec, 32'h1555);
        rd(`PRC_ADDR_PLLSTAT);
        check("lock", d, 32'h0);
        rd(32'h40048010);
        check("unmapped", d, 32'h0);
    endtask

    task automatic testLock(input logic lvl);
        @(posedge sys_clk);
        pllLockRaw <= lvl;
        repeat (3) @(posedge sys_clk);
        #1 check("lock change", pllLockChange, 32'h1);
        rd(`PRC_ADDR_PLLSTAT);
        check("lock", d, {31'h0, lvl});
    endtask

    task automatic closeOut;
        $display("Mismatches %0d of %0d compares", errCount, compares);
        if (errCount == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    always #10 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errCount++;
            closeOut;
        end
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        checkReset;
        testPreset;
        testPll;
        testStray;
        testLock(1'b1);
        testLock(1'b0);
        @(posedge sys_clk);
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        #1 checkReset;
        closeOut;
    end
endmodule

`default_nettype wire
